// [verilog/abd_bridge.sv]
// Host-to-PCI bridge absent-device claim, address-error conversion and lock check
`timescale 1ns/100ps
`default_nettype none
`include "abd_cfg.svh"

// Function
// (RULE1) 16-bit writable absent-device map at CCh, reset 00h.
// (RULE2) Map bit n covers host device ID n+16; one means unpopulated.
// (RULE3) Set bit: claim offset-00h reads to that ID, forward to PCI.
// (RULE4) Clear bit or default map: watchdog times out and claims the read.
// (RULE5) Software scans IDs 16-31 and sets bits of IDs answering all ones.
// (RULE6) Aliased mode bit 3: locks to shadowed BIOS unsupported, host avoids them.
// (RULE7) Software picks another BIOS mapping when locks needed in aliased mode.
// (RULE8) Enable bit 1 at C0h turns address parity errors into bus errors.
// (RULE9) Extended error command resets to 0000_0010h, enable in bit 1.
// (RULE10) Map reads back last write; clear-bit IDs decode unchanged.
module abd_bridge (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire abd_pkg::abd_cfg_req_t i_cfg_req,
   output logic o_cfg_ack,
   output logic [31:0] o_cfg_rdata,
   input wire abd_pkg::abd_host_rd_t i_host_rd,
   input wire logic i_target_claim,
   output logic o_pos_claim,
   output logic o_wdt_claim,
   input wire logic i_address_parity_error_signal_n,
   output logic o_host_bus_error_signal_n,
   input wire logic i_lock_bios_req,
   output logic o_lock_reject,
   output logic o_aliased_mode
);
   import abd_pkg::*;

   localparam int WDT_MAX = `ABD_WDT_CYCLES;

   logic [7:0] decode_mode;
   logic [31:0] ext_err_cmd;
   logic [15:0] absent_map;
   abd_state_t state;
   abd_state_t next_state;
   logic [15:0] wdt_cnt;
   logic [2:0] addr_err_sync;
   logic addr_err_level;
   logic addr_err_level_d;

   // Byte-lane merge used by the extended error command and absent-device map registers
   function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] be);
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Positive-decode test: bus 0, ID offset, device 16..31 with its map bit set
   // (RULE2) bit n covers ID n+16
   function automatic logic map_hit(input logic [15:0] map, input abd_host_rd_t rd);
      logic [4:0] idx;
      idx = rd.dev - `ABD_DEV_BASE;
      return rd.bus_zero && (rd.offset == `ABD_ID_OFFSET) && (rd.dev >= `ABD_DEV_BASE) &&
             map[idx[3:0]];
   endfunction

   wire cfg_wr = i_cfg_req.valid && i_cfg_req.write;

   // Decode mode register, only the aliased bit matters here
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         decode_mode <= `ABD_RST_DECODE_MODE;
      end else if (cfg_wr && i_cfg_req.offset == `ABD_OFS_DECODE_MODE && i_cfg_req.be[0]) begin
         decode_mode <= i_cfg_req.wdata[7:0];
      end
   end

   // Extended error command: only the conversion enable is writable
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         // (RULE9) reset value
         ext_err_cmd <= `ABD_RST_EXT_ERR_CMD;
      end else if (cfg_wr && i_cfg_req.offset == `ABD_OFS_EXT_ERR_CMD) begin
         ext_err_cmd <= (`ABD_RST_EXT_ERR_CMD & ~`ABD_MASK_EXT_ERR_CMD) |
                        (be_merge(ext_err_cmd, i_cfg_req.wdata, i_cfg_req.be) &
                         `ABD_MASK_EXT_ERR_CMD);
      end
   end

   // Absent-device map, two byte lanes
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         // (RULE1) map storage and reset
         absent_map <= `ABD_RST_ABSENT_MAP;
      end else if (cfg_wr && i_cfg_req.offset == `ABD_OFS_ABSENT_MAP) begin
         // Upper half of the merged word has no storage, so it is cut on purpose
         absent_map <= 16'(be_merge({16'h0000, absent_map}, i_cfg_req.wdata, i_cfg_req.be));
      end
   end

   // Register read-back; unmapped offsets read zero, ack one cycle after any access
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_cfg_ack <= 1'b0;
         o_cfg_rdata <= 32'h0000_0000;
      end else begin
         o_cfg_ack <= i_cfg_req.valid;
         o_cfg_rdata <= 32'h0000_0000;
         if (i_cfg_req.valid && !i_cfg_req.write) begin
            unique case (i_cfg_req.offset)
               `ABD_OFS_DECODE_MODE: o_cfg_rdata <= {24'h000000, decode_mode};
               `ABD_OFS_EXT_ERR_CMD: o_cfg_rdata <= ext_err_cmd;
               // (RULE10) map reads back last write
               `ABD_OFS_ABSENT_MAP: o_cfg_rdata <= {16'h0000, absent_map};
               default: o_cfg_rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // Claim state: one request outstanding; new requests are ignored while waiting
   always_comb begin
      next_state = state;
      unique case (state)
         ABD_IDLE: begin
            if (i_host_rd.valid && !map_hit(absent_map, i_host_rd)) begin
               next_state = ABD_WAIT;
            end
         end
         ABD_WAIT: begin
            if (i_target_claim || wdt_cnt == 16'(WDT_MAX - 1)) begin
               next_state = ABD_IDLE;
            end
         end
         default: next_state = ABD_IDLE;
      endcase
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         state <= ABD_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Watchdog counter runs only while a read waits for a claimant
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || state == ABD_IDLE) begin
         wdt_cnt <= 16'h0000;
      end else begin
         wdt_cnt <= wdt_cnt + 16'h0001;
      end
   end

   // Claim pulses
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_pos_claim <= 1'b0;
         o_wdt_claim <= 1'b0;
      end else begin
         // (RULE3) positive decode of absent IDs, forwarded to PCI
         o_pos_claim <= state == ABD_IDLE && i_host_rd.valid && map_hit(absent_map, i_host_rd);
         // (RULE4) watchdog claims what nobody else took
         o_wdt_claim <= state == ABD_WAIT && !i_target_claim && wdt_cnt == 16'(WDT_MAX - 1);
      end
   end

   // Pin synchroniser; a change counts once stages two and three agree
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         addr_err_sync <= 3'h0;
         addr_err_level <= 1'b0;
         addr_err_level_d <= 1'b0;
      end else begin
         addr_err_sync <= {addr_err_sync[1:0], ~i_address_parity_error_signal_n};
         if (addr_err_sync[1] == addr_err_sync[2]) begin
            addr_err_level <= addr_err_sync[2];
         end
         addr_err_level_d <= addr_err_level;
      end
   end

   // One bus-error pulse per detected assertion, gated by the enable
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_host_bus_error_signal_n <= 1'b1;
      end else begin
         // (RULE8) conversion of address errors
         o_host_bus_error_signal_n <= ~(addr_err_level && !addr_err_level_d &&
                                        ext_err_cmd[`ABD_BIT_ADDR_ERR_CONV]);
      end
   end

   // Locks to shadowed BIOS are refused in aliased mode rather than mishandled
   always_ff @(posedge i_ref_clk) begin
      if (i_srst) begin
         o_lock_reject <= 1'b0;
         o_aliased_mode <= 1'b0;
      end else begin
         // (RULE6) flag unsupported lock
         o_lock_reject <= i_lock_bios_req && decode_mode[`ABD_BIT_ALIASED];
         o_aliased_mode <= decode_mode[`ABD_BIT_ALIASED];
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);

   a_map_claim: assert property ( // (RULE3)
      state == ABD_IDLE && i_host_rd.valid && map_hit(absent_map, i_host_rd) |=> o_pos_claim)
      else $error("absent ID read not claimed");
   a_no_false_claim: assert property ( // (RULE10)
      o_pos_claim |-> $past(map_hit(absent_map, i_host_rd)))
      else $error("claim for present ID");
   a_default_wdt: assert property ( // (RULE4)
      state == ABD_IDLE && i_host_rd.valid && absent_map == `ABD_RST_ABSENT_MAP |=> !o_pos_claim)
      else $error("default map positively claimed");
   a_wdt_bound: assert property ( // (RULE4)
      state == ABD_WAIT && !i_target_claim && wdt_cnt == 16'(WDT_MAX - 1) |=> o_wdt_claim)
      else $error("watchdog did not claim");
   a_wdt_exclusive: assert property ( // (RULE4)
      !(o_wdt_claim && o_pos_claim))
      else $error("double claim");
   a_map_write: assert property ( // (RULE1)
      cfg_wr && i_cfg_req.offset == `ABD_OFS_ABSENT_MAP && i_cfg_req.be[1:0] == 2'h3
      |=> absent_map == $past(i_cfg_req.wdata[15:0]))
      else $error("map write lost");
   a_bus_err_pulse: assert property ( // (RULE8)
      $rose(addr_err_level) && ext_err_cmd[`ABD_BIT_ADDR_ERR_CONV] |=> !o_host_bus_error_signal_n)
      else $error("bus error missing");
   a_bus_err_gate: assert property ( // (RULE8)
      !o_host_bus_error_signal_n |-> $past(ext_err_cmd[`ABD_BIT_ADDR_ERR_CONV]))
      else $error("bus error while disabled");
   a_errcmd_fixed: assert property ( // (RULE9)
      (ext_err_cmd & ~`ABD_MASK_EXT_ERR_CMD) == (`ABD_RST_EXT_ERR_CMD & ~`ABD_MASK_EXT_ERR_CMD))
      else $error("fixed error command bits changed");
   a_lock_reject: assert property ( // (RULE6)
      i_lock_bios_req && decode_mode[`ABD_BIT_ALIASED] |=> o_lock_reject)
      else $error("aliased lock not flagged");

   c_pos_claim: cover property (o_pos_claim);
   c_wdt_claim: cover property (o_wdt_claim);
   c_target_claim: cover property (state == ABD_WAIT && i_target_claim);
   c_bus_err: cover property (!o_host_bus_error_signal_n);
endmodule // abd_bridge
`default_nettype wire

// [verilog/abd_cfg.svh]
// Offsets, reset values, field positions and timing counts of the absent-device claim block
`ifndef ABD_CFG_SVH
`define ABD_CFG_SVH
`define ABD_OFS_DECODE_MODE 8'h48
`define ABD_OFS_EXT_ERR_CMD 8'hc0
`define ABD_OFS_ABSENT_MAP 8'hcc
`define ABD_RST_DECODE_MODE 8'h06
`define ABD_RST_EXT_ERR_CMD 32'h0000_0010
`define ABD_RST_ABSENT_MAP 16'h0000
`define ABD_BIT_ALIASED 3
`define ABD_BIT_ADDR_ERR_CONV 1
`define ABD_MASK_EXT_ERR_CMD 32'h0000_0002
`define ABD_DEV_BASE 5'h10
`define ABD_ID_OFFSET 8'h00
`define ABD_WDT_TIME_NS 1280
`define ABD_CLK_NS 20
`define ABD_WDT_CYCLES (`ABD_WDT_TIME_NS / `ABD_CLK_NS)
`endif

// [verilog/abd_pkg.sv]
// Types shared by the absent-device claim block
package abd_pkg;
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] offset;
      logic [3:0] be;
      logic [31:0] wdata;
   } abd_cfg_req_t;
   typedef struct packed {
      logic valid;
      logic bus_zero;
      logic [4:0] dev;
      logic [7:0] offset;
   } abd_host_rd_t;
   typedef enum logic [1:0] {
      ABD_IDLE = 2'b01,
      ABD_WAIT = 2'b10
   } abd_state_t;
endpackage : abd_pkg

// [verif/abd_far_agent.sv]
// Far-side target model that may claim a pending configuration read
`timescale 1ns/100ps
`default_nettype none
module abd_far_agent (
   input wire logic i_ref_clk,
   input wire logic i_srst,
   input wire abd_pkg::abd_host_rd_t i_host_rd,
   input wire logic [7:0] i_delay,
   output logic o_target_claim
);
   import abd_pkg::*;
   logic [7:0] count;
   // absent targets silent
   // Zero delay means nobody answers, so the bridge must resolve the read itself
   always_ff @(posedge i_ref_clk) begin
      if (i_srst || (i_host_rd.valid && i_delay == 8'h00)) begin
         count <= 8'h00;
      end else if (i_host_rd.valid) begin
         count <= i_delay;
      end else if (count != 8'h00) begin
         count <= count - 8'h01;
      end
   end
   assign o_target_claim = (count == 8'h01); // One-cycle claim
endmodule // abd_far_agent
`default_nettype wire

// [verif/testbench.sv]
// Self-checking bench for the absent-device claim bridge
`timescale 1ns/100ps
`default_nettype none
`include "abd_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
   import abd_pkg::*;
   logic clk = 1'b0;
   logic srst = 1'b1;
   abd_cfg_req_t cfg_req = '0;
   abd_host_rd_t host_rd = '0;
   logic addr_err_n = 1'b1;
   logic lock_req = 1'b0;
   logic [7:0] delay = 8'h00;
   logic tclaim, ack, pos, wdt, bus_err_n, reject, aliased;
   // Watchdog claim lands a full count after the request edge, plus the output register
   localparam int WDT_WANT = `ABD_WDT_CYCLES + 1;
   logic [31:0] rdata, map = 32'h0, seed = 32'h8549;
   logic [36:0] expq[$];
   logic [36:0] obs, exp_v;
   int mismatches = 0, checked = 0, cnt;
   abd_bridge u_abd_bridge (.i_ref_clk(clk), .i_srst(srst), .i_cfg_req(cfg_req),
      .o_cfg_ack(ack), .o_cfg_rdata(rdata), .i_host_rd(host_rd), .i_target_claim(tclaim),
      .o_pos_claim(pos), .o_wdt_claim(wdt), .i_address_parity_error_signal_n(addr_err_n),
      .o_host_bus_error_signal_n(bus_err_n), .i_lock_bios_req(lock_req),
      .o_lock_reject(reject), .o_aliased_mode(aliased));
   abd_far_agent u_abd_far_agent (.i_ref_clk(clk), .i_srst(srst), .i_host_rd(host_rd),
      .i_delay(delay), .o_target_claim(tclaim));
   // Free-running clock
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic close_out;
      $display("checked %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // One config access; the expected answer is queued before it can appear
   task automatic cfg(input logic w, input logic [7:0] off, input logic [31:0] d,
                      input logic [31:0] e);
      @(posedge clk);
      cfg_req <= '{1'b1, w, off, 4'hf, d};
      expq.push_back({5'b10000, e});
      @(posedge clk);
      cfg_req.valid <= 1'b0;
   endtask
   // Host read; want is the expected claim latency, zero when none is due
   task automatic host(input logic [4:0] dev, input logic [7:0] off, input logic [7:0] dl,
                       input logic [4:0] code, input int want);
      @(posedge clk);
      host_rd <= '{1'b1, 1'b1, dev, off};
      delay <= dl;
      if (code != 5'h0) expq.push_back({code, 32'h0});
      cnt = 0;
      repeat (80) begin
         @(posedge clk);
         host_rd.valid <= 1'b0;
         #1;
         cnt++;
         if (pos || wdt) break;
      end
      if (want > 0) `CHK(cnt, want)
   endtask
   // Pulse the lock request or hold the address error pin low for a while
   task automatic pulse(input bit is_lock, input logic [4:0] code);
      if (code != 5'h0) expq.push_back({code, 32'h0});
      @(posedge clk);
      if (is_lock) lock_req <= 1'b1;
      else addr_err_n <= 1'b0;
      @(posedge clk);
      lock_req <= 1'b0;
      repeat (8) @(posedge clk);
      addr_err_n <= 1'b1;
      repeat (4) @(posedge clk);
   endtask
   // Watcher: every output event takes the oldest queued note
   always @(posedge clk) begin
      #1;
      obs = {ack, pos, wdt, !bus_err_n, reject, rdata};
      if (obs[36:32] != 5'h0) begin
         exp_v = (expq.size() > 0) ? expq.pop_front() : 37'h0;
         `CHK(obs, exp_v)
      end
   end
   // Hang guard, well beyond the few thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      close_out();
   end
   initial begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      cfg(0, 8'h48, 0, 32'h06);
      cfg(0, 8'hc0, 0, 32'h10);
      cfg(0, 8'hcc, 0, 32'h0);
      cfg(0, 8'h44, 0, 32'h0);
      cfg(1, 8'hc0, 32'hffffffff, 0);
      cfg(0, 8'hc0, 0, 32'h12);
      $display("test registers done");
      // Default map first, then a random map written as the scan would leave it
      for (int r = 0; r < 2; r++) begin
         if (r == 1) begin
            seed = xs(seed);
            map = {16'h0, seed[15:0]};
            cfg(1, 8'hcc, map, 0);
            cfg(0, 8'hcc, 0, map);
         end
         for (int n = 0; n < 16; n++) begin
            if (map[n]) host(5'(16 + n), 8'h00, 8'h00, 5'b01000, 1);
            else if (n[0]) host(5'(16 + n), 8'h00, 8'd10, 5'h0, 0);
            else host(5'(16 + n), 8'h00, 8'h00, 5'b00100, WDT_WANT);
         end
      end
      cfg(1, 8'hcc, 32'hffff, 0);
      host(5'h10, 8'h04, 8'h00, 5'b00100, WDT_WANT);
      host(5'h0f, 8'h00, 8'h00, 5'b00100, WDT_WANT);
      $display("test claims done");
      cfg(1, 8'hc0, 32'h2, 0);
      pulse(0, 5'b00010);
      cfg(1, 8'hc0, 32'h0, 0);
      pulse(0, 5'h0);
      $display("test address error done");
      cfg(1, 8'h48, 32'h0e, 0);
      repeat (2) @(posedge clk);
      #1 `CHK(aliased, 1'b1)
      pulse(1, 5'b00001);
      // later locks only outside aliased mode
      cfg(1, 8'h48, 32'h06, 0);
      pulse(1, 5'h0);
      $display("test lock done");
      `CHK(expq.size(), 0)
      close_out();
   end
endmodule // testbench
`default_nettype wire
